//--- rtl/bmc_matrix_cfg.sv
/*
 * Bus matrix configuration and status block: configuration register,
 * read-only data RAM size, user flash base, bus error gating per
 * initiator, DMA cache allocation control, data RAM setup wait state
 * and a sticky interrupt status with mask.
 * Assumes all matrix side inputs are on ref_clk_i and a classic
 * Wishbone master on the register side.
 */
// The register offsets and the Wishbone slave port were left to the implementer.
`timescale 1ns/100ps

// How it works
// - Config bit 26 set lets DMA flash misses allocate when cache data caching is on.
// - Bit 26 clear: DMA hits still served from cache, misses never allocate.
// - Bit 20 gates bus errors for unmapped accesses from the shared bus.
// - Bit 19 gates bus errors for unmapped accesses from the debug unit.
// - Bit 18 gates bus errors for unmapped accesses from the DMA.
// - Bit 17 gates CPU data bus errors; no effect in debug mode.
// - Bit 16 gates CPU fetch bus errors; no effect in debug mode.
// - Bit 6 adds one address setup wait state to CPU data RAM accesses.
// - Arbitration field codes 000, 001, 010 pick modes 0-2; mode 1 at reset.
// - RAM size register is read-only and returns the fixed byte count.
// - User flash base bits 19:11 writable, bits 10:0 always zero.
// - Reset clears the user flash base, giving all memory to kernel use.
// - Unimplemented configuration bits always read as zero.
module bmc_matrix_cfg #(
    parameter logic [31:0] RAM_SIZE_VALUE   = bmc_pkg::RAM_64K,
    parameter logic [31:0] FLASH_SIZE_VALUE = bmc_pkg::FLASH_SIZE_DEF
) (
    // Clock and reset
    input  wire logic        ref_clk_i,
    input  wire logic        reset_i,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Matrix side: unmapped access reports and debug state
    input  wire logic [bmc_pkg::N_INIT-1:0] unmapped_i,
    input  wire logic        debug_mode_i,
    output logic      [bmc_pkg::N_INIT-1:0] bus_err_o,
    // DMA program flash reads against the cache
    input  wire logic        cache_data_en_i,
    input  wire logic        dma_flash_rd_i,
    input  wire logic        dma_cache_hit_i,
    output logic             dma_hit_serve_o,
    output logic             dma_alloc_o,
    // CPU data RAM access
    input  wire logic        cpu_ram_req_i,
    output logic             ram_go_o,
    // Configuration to the matrix
    output logic      [bmc_pkg::ARB_W-1:0] arb_mode_sel_o,
    output logic             ram_setup_wait_o,
    output logic      [31:0] user_flash_base_o,
    // Interrupt
    output logic             irq_o
);
    import bmc_pkg::*;

    logic [31:0]       cfg_r;
    logic [31:0]       ufb_r;
    logic [N_EV-1:0]   stat_r;
    logic [N_EV-1:0]   mask_r;
    logic [N_EV-1:0]   stat_nxt;
    logic [N_EV-1:0]   ev_set;
    logic [N_INIT-1:0] err_gate;
    logic [31:0]       rd_nxt;
    logic              wb_req;
    logic              wb_wr;
    logic              arb_rsv_wr;
    logic              ack_r;
    logic              irq_r;
    logic              alloc_r;
    logic              hit_r;
    logic [N_INIT-1:0] err_r;
    bmc_ram_st_t       ram_st_r;
    bmc_ram_st_t       ram_st_nxt;

    // Byte-lane merge restricted to writable bits; other bits keep old value
    function automatic logic [31:0] wr_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  sel,
                                             input logic [31:0] wmask);
        logic [31:0] lane;
        lane = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
        return (old_v & ~(lane & wmask)) | (new_v & lane & wmask);
    endfunction

    // Offset match on the word address; low two bits are byte lanes
    function automatic logic hit_off(input logic [7:0] adr, input logic [7:0] off);
        return adr[7:2] == off[7:2];
    endfunction

    // A request is taken on the edge that raises ack
    assign wb_req     = wb_cyc_i && wb_stb_i && !ack_r;
    assign wb_wr      = wb_req && wb_we_i;
    assign arb_rsv_wr = wb_wr && hit_off(wb_adr_i, OFF_CONFIG) && wb_sel_i[0]
                        && (wb_dat_i[ARB_W-1:0] > ARB_MODE2);

    // Bus ack: one cycle after the request, dropped the cycle after
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= wb_req;
        end
    end

    // Configuration register; reserved arbitration codes are stored as
    // written since their effect is left to the matrix
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            cfg_r <= CFG_RESET;
        end else if (wb_wr && hit_off(wb_adr_i, OFF_CONFIG)) begin
            cfg_r <= wr_merge(cfg_r, wb_dat_i, wb_sel_i, CFG_WMASK);
        end
    end

    // User flash base: only 2 KB granules are writable
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            ufb_r <= UFB_RESET;
        end else if (wb_wr && hit_off(wb_adr_i, OFF_UFB)) begin
            ufb_r <= wr_merge(ufb_r, wb_dat_i, wb_sel_i, UFB_WMASK);
        end
    end

    // Interrupt mask, low byte lane only
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            mask_r <= EV_RESET;
        end else if (wb_wr && hit_off(wb_adr_i, OFF_INT_MASK) && wb_sel_i[0]) begin
            mask_r <= wb_dat_i[N_EV-1:0];
        end
    end

    // Read mux; unmapped offsets and the size registers ignore writes
    always_comb begin
        rd_nxt = 32'h00000000;
        if (hit_off(wb_adr_i, OFF_CONFIG)) begin
            rd_nxt = cfg_r & CFG_WMASK;
        end else if (hit_off(wb_adr_i, OFF_RAM_SIZE)) begin
            rd_nxt = RAM_SIZE_VALUE;
        end else if (hit_off(wb_adr_i, OFF_UFB)) begin
            rd_nxt = ufb_r & UFB_WMASK;
        end else if (hit_off(wb_adr_i, OFF_FLASH_SIZE)) begin
            rd_nxt = FLASH_SIZE_VALUE;
        end else if (hit_off(wb_adr_i, OFF_INT_STAT)) begin
            rd_nxt = {26'h0000000, stat_r};
        end else if (hit_off(wb_adr_i, OFF_INT_MASK)) begin
            rd_nxt = {26'h0000000, mask_r};
        end
    end

    // Read data is captured with the ack and held until the next read request
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            wb_dat_o <= 32'h00000000;
        end else if (wb_req && !wb_we_i) begin
            wb_dat_o <= rd_nxt;
        end
    end

    // Per-initiator gating; debug mode overrides the two CPU enables
    generate
        for (genvar i = 0; i < N_INIT; i++) begin : g_err
            if (i == INI_CPU_INSTR || i == INI_CPU_DATA) begin : g_cpu
                assign err_gate[i] = unmapped_i[i] && cfg_r[CFG_ERR_LSB+i]
                                     && !debug_mode_i;
            end else begin : g_other
                assign err_gate[i] = unmapped_i[i] && cfg_r[CFG_ERR_LSB+i];
            end
        end
    endgenerate

    // Bus error pulses to the initiators, one cycle after the report
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            err_r <= '0;
        end else begin
            err_r <= err_gate;
        end
    end

    // Sticky status: a new event wins over a write-one-to-clear
    assign ev_set = {arb_rsv_wr, err_gate};
    always_comb begin
        stat_nxt = stat_r;
        if (wb_wr && hit_off(wb_adr_i, OFF_INT_STAT) && wb_sel_i[0]) begin
            stat_nxt = stat_nxt & ~wb_dat_i[N_EV-1:0];
        end
        stat_nxt = stat_nxt | ev_set;
    end

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            stat_r <= EV_RESET;
        end else begin
            stat_r <= stat_nxt;
        end
    end

    // Level interrupt, registered so it lags status by one cycle
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(stat_r & mask_r);
        end
    end

    // DMA flash reads: hits always served, misses allocate only when allowed
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            hit_r   <= 1'b0;
            alloc_r <= 1'b0;
        end else begin
            hit_r   <= dma_flash_rd_i && dma_cache_hit_i;
            alloc_r <= dma_flash_rd_i && !dma_cache_hit_i
                       && cfg_r[CFG_CACHE_DMA] && cache_data_en_i;
        end
    end

    // CPU data RAM sequencing: optional setup cycle before the access
    always_comb begin
        case (ram_st_r)
            RAM_IDLE: begin
                if (!cpu_ram_req_i) begin
                    ram_st_nxt = RAM_IDLE;
                end else if (cfg_r[CFG_RAM_WAIT]) begin
                    ram_st_nxt = RAM_SETUP;
                end else begin
                    ram_st_nxt = RAM_GO;
                end
            end
            RAM_SETUP: begin
                ram_st_nxt = cpu_ram_req_i ? RAM_GO : RAM_IDLE;
            end
            RAM_GO: begin
                ram_st_nxt = RAM_IDLE;
            end
            default: begin
                ram_st_nxt = RAM_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            ram_st_r <= RAM_IDLE;
        end else begin
            ram_st_r <= ram_st_nxt;
        end
    end

    // Outputs straight from flops
    assign wb_ack_o          = ack_r;
    assign bus_err_o         = err_r;
    assign dma_hit_serve_o   = hit_r;
    assign dma_alloc_o       = alloc_r;
    assign ram_go_o          = ram_st_r[2];
    assign arb_mode_sel_o    = cfg_r[CFG_ARB_LSB +: ARB_W];
    assign ram_setup_wait_o  = cfg_r[CFG_RAM_WAIT];
    assign user_flash_base_o = ufb_r;
    assign irq_o             = irq_r;

    // Checks on the block's own behaviour
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);

    AST_DMA_ALLOC: assert property (
        dma_flash_rd_i && !dma_cache_hit_i && cache_data_en_i && cfg_r[CFG_CACHE_DMA]
        |=> dma_alloc_o)
        else $error("DMA miss did not allocate while cacheable");

    AST_DMA_NO_ALLOC: assert property (
        !cfg_r[CFG_CACHE_DMA] |=> !dma_alloc_o)
        else $error("DMA miss allocated while not cacheable");

    AST_DMA_HIT: assert property (
        dma_flash_rd_i && dma_cache_hit_i |=> dma_hit_serve_o && !dma_alloc_o)
        else $error("DMA hit not served from cache");

    AST_ERR_SHARED: assert property (
        unmapped_i[INI_SHARED] |=> bus_err_o[INI_SHARED] == $past(cfg_r[CFG_ERR_LSB+INI_SHARED]))
        else $error("Shared bus error gating wrong");

    AST_ERR_DEBUG: assert property (
        unmapped_i[INI_DEBUG] |=> bus_err_o[INI_DEBUG] == $past(cfg_r[CFG_ERR_LSB+INI_DEBUG]))
        else $error("Debug unit error gating wrong");

    AST_ERR_DMA: assert property (
        !cfg_r[CFG_ERR_LSB+INI_DMA] |=> !bus_err_o[INI_DMA])
        else $error("DMA bus error raised while disabled");

    AST_ERR_CPU_DATA: assert property (
        unmapped_i[INI_CPU_DATA] && cfg_r[CFG_ERR_LSB+INI_CPU_DATA]
        |=> bus_err_o[INI_CPU_DATA] == !$past(debug_mode_i))
        else $error("CPU data error wrong around debug mode");

    AST_ERR_CPU_INSTR: assert property (
        debug_mode_i |=> !bus_err_o[INI_CPU_INSTR])
        else $error("CPU fetch error raised in debug mode");

    AST_RAM_WAIT: assert property (
        ram_st_r == RAM_IDLE && cpu_ram_req_i && ram_setup_wait_o
        |=> !ram_go_o ##1 (ram_go_o == $past(cpu_ram_req_i)))
        else $error("Setup wait state not inserted");

    AST_RAM_NOWAIT: assert property (
        ram_st_r == RAM_IDLE && cpu_ram_req_i && !ram_setup_wait_o |=> ram_go_o)
        else $error("Zero wait access delayed");

    AST_ARB_RESET: assert property (
        $past(reset_i) |-> arb_mode_sel_o == ARB_MODE1)
        else $error("Arbitration mode not 1 after reset");

    AST_RAM_SIZE_RD: assert property (
        wb_req && !wb_we_i && hit_off(wb_adr_i, OFF_RAM_SIZE) |=> wb_ack_o && wb_dat_o == RAM_SIZE_VALUE)
        else $error("RAM size read wrong");

    AST_UFB_LOW: assert property (
        user_flash_base_o[10:0] == 11'h000 && user_flash_base_o[31:20] == 12'h000)
        else $error("User flash base fixed bits not zero");

    AST_UFB_RESET: assert property (
        $past(reset_i) |-> user_flash_base_o == UFB_RESET)
        else $error("User flash base not cleared by reset");

    AST_CFG_RSV: assert property (
        wb_req && !wb_we_i && hit_off(wb_adr_i, OFF_CONFIG) |=> (wb_dat_o & ~CFG_WMASK) == 32'h00000000)
        else $error("Unimplemented config bits read nonzero");

    AST_RO_WRITE: assert property (
        wb_wr && !hit_off(wb_adr_i, OFF_CONFIG) && !hit_off(wb_adr_i, OFF_UFB) |=> $stable(cfg_r) && $stable(ufb_r))
        else $error("Write elsewhere changed configuration");

    AST_SET_WINS: assert property (
        |ev_set |=> (stat_r & $past(ev_set)) == $past(ev_set))
        else $error("Status event lost against clear");
endmodule

//--- rtl/bmc_pkg.sv
/*
 * Package of the bus matrix configuration block: register offsets,
 * field positions, reset values, initiator numbering and encodings.
 * Assumes a 32-bit classic Wishbone register bus with byte addresses.
 */
package bmc_pkg;
    // Register byte offsets
    localparam logic [7:0]  OFF_CONFIG     = 8'h00;
    localparam logic [7:0]  OFF_RAM_SIZE   = 8'h04;
    localparam logic [7:0]  OFF_UFB        = 8'h08;
    localparam logic [7:0]  OFF_FLASH_SIZE = 8'h0c;
    localparam logic [7:0]  OFF_INT_STAT   = 8'h10;
    localparam logic [7:0]  OFF_INT_MASK   = 8'h14;

    // Configuration register fields
    localparam int          CFG_CACHE_DMA  = 26;
    localparam int          CFG_ERR_LSB    = 16;
    localparam int          CFG_RAM_WAIT   = 6;
    localparam int          CFG_ARB_LSB    = 0;
    localparam int          ARB_W          = 3;
    localparam logic [31:0] CFG_RESET      = 32'h041f0041;
    localparam logic [31:0] CFG_WMASK      = 32'h041f0047;

    // User flash base register
    localparam logic [31:0] UFB_RESET      = 32'h00000000;
    localparam logic [31:0] UFB_WMASK      = 32'h000ff800;

    // Data RAM byte counts and a plain flash size default
    localparam logic [31:0] RAM_16K        = 32'h00004000;
    localparam logic [31:0] RAM_32K        = 32'h00008000;
    localparam logic [31:0] RAM_64K        = 32'h00010000;
    localparam logic [31:0] RAM_128K       = 32'h00020000;
    localparam logic [31:0] FLASH_SIZE_DEF = 32'h00040000;

    // Initiators, in configuration bit order from CFG_ERR_LSB
    localparam int          N_INIT         = 5;
    localparam int          INI_CPU_INSTR  = 0;
    localparam int          INI_CPU_DATA   = 1;
    localparam int          INI_DMA        = 2;
    localparam int          INI_DEBUG      = 3;
    localparam int          INI_SHARED     = 4;

    // Interrupt events: one per initiator plus reserved arbitration write
    localparam int          N_EV           = 6;
    localparam int          EV_ARB_RSV     = 5;
    localparam logic [5:0]  EV_RESET       = 6'h00;

    typedef enum logic [2:0] {
        ARB_MODE0 = 3'h0,
        ARB_MODE1 = 3'h1,
        ARB_MODE2 = 3'h2
    } bmc_arb_t;

    typedef enum logic [2:0] {
        RAM_IDLE  = 3'h1,
        RAM_SETUP = 3'h2,
        RAM_GO    = 3'h4
    } bmc_ram_st_t;
endpackage

//--- tb/bmc_init_model.sv
/*
 * Model of the initiators beside the bus matrix: unmapped access
 * reports, DMA flash reads and CPU data RAM requests.
 * Assumes the bench calls its tasks and that all lines share ref_clk_i.
 */
`timescale 1ns/100ps
module bmc_init_model (
    // Clock
    input  wire logic                       ref_clk_i,
    // To and from the block
    output logic      [bmc_pkg::N_INIT-1:0] unmapped_o,
    output logic                     dma_flash_rd_o,
    output logic                     dma_cache_hit_o,
    output logic                     cpu_ram_req_o,
    input  wire logic                ram_go_i
);
    import bmc_pkg::*;

    // Idle lines at time zero
    initial begin
        unmapped_o      = '0;
        dma_flash_rd_o  = 1'b0;
        dma_cache_hit_o = 1'b0;
        cpu_ram_req_o   = 1'b0;
    end

    // One access report per initiator bit, a single cycle long
    task automatic fire(input logic [N_INIT-1:0] m);
        @(posedge ref_clk_i);
        unmapped_o <= m;
        @(posedge ref_clk_i);
        unmapped_o <= '0;
    endtask

    // Hit line flips outside a read so a stale value cannot pass
    task automatic dma_rd(input logic hit);
        @(posedge ref_clk_i);
        dma_flash_rd_o  <= 1'b1;
        dma_cache_hit_o <= hit;
        @(posedge ref_clk_i);
        dma_flash_rd_o  <= 1'b0;
        dma_cache_hit_o <= ~hit;
    endtask

    // Request held until the go pulse is sampled; n counts edges
    task automatic ram_access(output int n);
        n = 0;
        @(posedge ref_clk_i);
        cpu_ram_req_o <= 1'b1;
        @(posedge ref_clk_i);
        n = 1;
        while (ram_go_i !== 1'b1 && n < 20) begin
            @(posedge ref_clk_i);
            n++;
        end
        cpu_ram_req_o <= 1'b0;
    endtask
endmodule

//--- tb/bmc_matrix_cfg_tb_top.sv
/*
 * Self-checking bench of the bus matrix configuration block.
 * Assumes the Wishbone slave acks every access and the model
 * bmc_init_model stands on the matrix side.
 */
`timescale 1ns/100ps
module bmc_matrix_cfg_tb_top;
    import bmc_pkg::*;
    typedef struct packed {
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] wd;
        logic [31:0] exp;
    } bmc_row_t;
    // Write one row, read it back
    localparam bmc_row_t ROWS [9] = '{
        '{OFF_CONFIG,     4'hf, 32'hfffffff8, 32'h041f0040},
        '{OFF_CONFIG,     4'hf, 32'h00000002, 32'h00000002},
        '{OFF_CONFIG,     4'hf, 32'h00000000, 32'h00000000},
        '{OFF_CONFIG,     4'h8, 32'hffffffff, 32'h04000000},
        '{OFF_UFB,        4'hf, 32'hffffffff, 32'h000ff800},
        '{OFF_UFB,        4'h2, 32'h00000fff, 32'h000f0800},
        '{OFF_RAM_SIZE,   4'hf, 32'h00000000, RAM_32K},
        '{OFF_FLASH_SIZE, 4'hf, 32'h00000000, 32'h00100000},
        '{8'h20,          4'hf, 32'hffffffff, 32'h00000000}
    };
    // Case bits: cfg26, cache enable, hit, serve, alloc
    localparam logic [4:0] DMA_CASES [5] = '{5'b01110, 5'b01000, 5'b11001, 5'b10000, 5'b11110};
    logic              ref_clk;
    logic              reset;
    logic              cyc, stb, we, debug_mode, cache_en;
    logic [7:0]        adr;
    logic [3:0]        sel;
    logic [31:0]       wdat, rd;
    logic [31:0]       dat_o, ufb_o;
    logic              ack, dma_serve, dma_alloc, ram_go, ram_wait, irq;
    logic [N_INIT-1:0] unmapped, bus_err;
    logic              dma_rd, dma_hit, ram_req;
    logic [ARB_W-1:0]  arb;
    int                n_mismatch = 0;
    int                num_checks = 0;
    int                n;

    // Flash size raised so every base written stays within it
    bmc_matrix_cfg #(.RAM_SIZE_VALUE(RAM_32K), .FLASH_SIZE_VALUE(32'h00100000)) uut (
        .ref_clk_i(ref_clk), .reset_i(reset), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .unmapped_i(unmapped), .debug_mode_i(debug_mode), .bus_err_o(bus_err),
        .cache_data_en_i(cache_en), .dma_flash_rd_i(dma_rd), .dma_cache_hit_i(dma_hit),
        .dma_hit_serve_o(dma_serve), .dma_alloc_o(dma_alloc), .cpu_ram_req_i(ram_req),
        .ram_go_o(ram_go), .arb_mode_sel_o(arb), .ram_setup_wait_o(ram_wait),
        .user_flash_base_o(ufb_o), .irq_o(irq));
    bmc_init_model ini (
        .ref_clk_i(ref_clk), .unmapped_o(unmapped), .dma_flash_rd_o(dma_rd),
        .dma_cache_hit_o(dma_hit), .cpu_ram_req_o(ram_req), .ram_go_i(ram_go));

    // 125 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH reg t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_pin(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH pin t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Classic cycle: held until ack is sampled, released on that edge;
    // only the watchdog bounds the wait, so a lost ack still ends the run
    task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
        @(posedge ref_clk);
        {cyc, stb, we, adr, sel, wdat} <= {2'b11, w, a, s, d};
        @(posedge ref_clk);
        while (ack !== 1'b1) begin
            @(posedge ref_clk);
        end
        rd = dat_o;
        {cyc, stb, we} <= 3'b000;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wb(1'b1, a, 4'hf, d);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        wb(1'b0, a, 4'hf, 32'h0);
        chk_reg(rd, exp);
    endtask

    task automatic wrap_up();
        $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Whole run is under 200 cycles; this 5000-cycle limit allows over 25 times that
    initial begin
        #40000;
        n_mismatch++;
        $display("watchdog expired");
        wrap_up();
    end

    initial begin
        {cyc, stb, we, adr, sel, wdat, debug_mode, cache_en} = '0;
        reset = 1'b1;
        repeat (16) @(posedge ref_clk);
        reset <= 1'b0;
        chk_pin(arb, ARB_MODE1);
        chk_pin(ram_wait, 1'b1);
        rdc(OFF_CONFIG, CFG_RESET);
        rdc(OFF_UFB, 32'h0);
        $display("reset values done");
        for (int i = 0; i < 9; i++) begin
            wb(1'b1, ROWS[i].adr, ROWS[i].sel, ROWS[i].wd);
            rdc(ROWS[i].adr, ROWS[i].exp);
        end
        $display("register table done");
        for (int m = 0; m < 3; m++) begin
            // Only the defined codes are written; 011 to 111 stay unused
            wr(OFF_CONFIG, 32'h041f0040 | m);
            #1 chk_pin(arb, m);
        end
        wr(OFF_CONFIG, CFG_RESET);
        for (int i = 0; i < N_INIT; i++) begin
            ini.fire(5'h01 << i);
            #1 chk_pin(bus_err, 5'h01 << i);
        end
        @(posedge ref_clk) debug_mode <= 1'b1;
        ini.fire(5'h1f);
        #1 chk_pin(bus_err, 5'h1c);
        @(posedge ref_clk) debug_mode <= 1'b0;
        wr(OFF_CONFIG, CFG_RESET & ~32'h000a0000);
        ini.fire(5'h1f);
        #1 chk_pin(bus_err, 5'h15);
        $display("bus errors done");
        wr(OFF_INT_STAT, 32'h3f);
        rdc(OFF_INT_STAT, 32'h0);
        ini.fire(5'h10);
        repeat (2) @(posedge ref_clk);
        #1 chk_pin(irq, 1'b0);
        wr(OFF_INT_MASK, 32'h10);
        @(posedge ref_clk);
        #1 chk_pin(irq, 1'b1);
        rdc(OFF_INT_STAT, 32'h10);
        wr(OFF_INT_STAT, 32'h10);
        @(posedge ref_clk);
        #1 chk_pin(irq, 1'b0);
        // Event and clear of the same bit land on one edge: the event wins
        fork
            wr(OFF_INT_STAT, 32'h10);
            ini.fire(5'h10);
        join
        rdc(OFF_INT_STAT, 32'h10);
        $display("interrupts done");
        for (int i = 0; i < 5; i++) begin
            wr(OFF_CONFIG, CFG_RESET & ~32'h04000000 | {DMA_CASES[i][4], 26'h0});
            @(posedge ref_clk) cache_en <= DMA_CASES[i][3];
            ini.dma_rd(DMA_CASES[i][2]);
            #1 chk_pin({dma_serve, dma_alloc}, DMA_CASES[i][1:0]);
        end
        $display("dma cache done");
        ini.ram_access(n);
        chk_pin(32'(n), 32'd3);
        wr(OFF_CONFIG, CFG_RESET & ~32'h00000040);
        #1 chk_pin(ram_wait, 1'b0);
        ini.ram_access(n);
        chk_pin(32'(n), 32'd2);
        $display("ram wait done");
        wr(OFF_UFB, 32'h00003800);
        rdc(OFF_UFB, 32'h00003800);
        @(posedge ref_clk) reset <= 1'b1;
        repeat (2) @(posedge ref_clk);
        reset <= 1'b0;
        chk_pin(ufb_o, 32'h0);
        rdc(OFF_UFB, 32'h0);
        $display("second reset done");
        wrap_up();
    end
endmodule
